// ==== emsc_cfg.svh ====
// What this block does
// - Three modes, manual, off, auto, taken from the keyed selector input.
// - Manual mode gives manual control; interlocks block damaging manual motion commands.
// - Off starts controlled stop; off back to auto resumes at the stopped step.
// - Auto cycling starts only after the auto-start button; selecting auto alone does not.
// - White auto lamp is on while in auto idle, auto run or controlled halt; it stays off in fault, even with the selector at auto.
// - Controlled halt is entered only from auto, by the controlled-halt button.
// - In controlled halt the lamp blinks and the step number stays frozen.
// - Controlled halt drops motion outputs but keeps all sequencer state.
// - Emergency halt drops every motion output at the next clock edge.
// - Emergency halt removes output power except lamps and readouts.
// - Selector in off stops all motion in its area.
// - Selector in manual stops motion; only a manual action switch restarts it.
// - Each asserted emergency switch lights its own lamp and shows a diagnostic code.
// - Every emergency-halt button has its own separately observed input.
// - Resume restores power; auto stays blocked until machines are home.
// - After start-up, wait 15 seconds before any motion output.
// - Start-up horn sounds for the whole warning delay.
// - Temporary jam or peripheral-off shutdown restarts on its own when it clears.
// - After emergency halt, device jam or other error, stay stopped until operator restart.
// - A perimeter lanyard trip drives the local annunciator output.
// - Malfunction on action timeout, invalid state combination, or missing expected action.
// - Error display holds until the underlying error condition clears; a fault's code holds until error reset leaves the fault state.
`ifndef EMSC_CFG_SVH
`define EMSC_CFG_SVH
`define EMSC_CLK_HZ        40000000
`define EMSC_WARN_S        15
`define EMSC_WARN_CYC      (`EMSC_WARN_S * `EMSC_CLK_HZ)
`define EMSC_BLINK_HZ      2
`define EMSC_BLINK_CYC     (`EMSC_CLK_HZ / (2 * `EMSC_BLINK_HZ))
`define EMSC_ACT_TMO_CYC   200000000
`define EMSC_SEL_MANUAL    2'h1
`define EMSC_SEL_OFF       2'h0
`define EMSC_SEL_AUTO      2'h2
`define EMSC_ERR_NONE      8'h00
`define EMSC_ERR_TIMEOUT   8'h10
`define EMSC_ERR_INVALID   8'h11
`define EMSC_ERR_MISSING   8'h12
`define EMSC_ERR_JAM       8'h13
`define EMSC_ERR_ESTOP     8'h20
`define EMSC_ERR_LANYARD   8'h30
`endif

// ==== emsc_pkg.sv ====
`default_nettype none
package emsc_pkg;
    // Supervisor states
    typedef enum logic [2:0] {
        ST_WARN,
        ST_OFF,
        ST_MANUAL,
        ST_AUTO_IDLE,
        ST_AUTO_RUN,
        ST_CTRL_HALT,
        ST_ESTOP,
        ST_FAULT
    } emsc_state_t;
endpackage : emsc_pkg
`default_nettype wire

// ==== emsc_mode_stop.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emsc_cfg.svh"
module emsc_mode_stop #(
    parameter int N_ESTOP   = 4,
    parameter int N_ACT     = 4,
    parameter int STEP_W    = 8,
    parameter int WARN_CYC  = `EMSC_WARN_CYC,
    parameter int BLINK_CYC = `EMSC_BLINK_CYC,
    parameter int TMO_CYC   = `EMSC_ACT_TMO_CYC
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // Operator controls
    input  wire logic [1:0]        i_mode_selector,
    input  wire logic              i_auto_start,
    input  wire logic              i_ctrl_halt,
    input  wire logic              i_ctrl_halt_reset,
    input  wire logic              i_resume,
    input  wire logic              i_error_reset,
    input  wire logic              i_alarm_mute_button,
    input  wire logic [N_ESTOP-1:0] i_estop,
    input  wire logic              i_lanyard_trip,
    input  wire logic [N_ACT-1:0]  i_manual_action_switches,
    // Machine feedback
    input  wire logic [N_ACT-1:0]  i_interlock_ok,
    input  wire logic              i_at_home,
    input  wire logic              i_step_done,
    input  wire logic              i_flow_jam_tmp,
    input  wire logic              i_periph_off_tmp,
    input  wire logic              i_device_jam,
    input  wire logic              i_invalid_combo,
    input  wire logic              i_expected_missing,
    // Motion and power
    output logic [N_ACT-1:0]       o_motion_en,
    output logic                   o_seq_run,
    output logic [STEP_W-1:0]      o_seq_step,
    output logic                   o_homing,
    output logic                   o_out_power,
    // Lamps, horn and readouts
    output logic                   o_auto_lamp,
    output logic                   o_ctrl_halt_lamp,
    output logic [N_ESTOP-1:0]     o_estop_lamp,
    output logic                   o_lanyard_annunc,
    output logic                   o_startup_horn,
    output logic                   o_error_lamp,
    output logic                   o_audible_alarm,
    output logic [7:0]             o_error_code
);
    // =====================================================
    // State registers
    emsc_pkg::emsc_state_t state_ff, nxt_state;
    logic [31:0]       tmr_ff, nxt_tmr;
    logic [31:0]       blk_ff, nxt_blk;
    logic [31:0]       tmo_ff, nxt_tmo;
    logic [STEP_W-1:0] step_ff, nxt_step;
    logic              warned_ff, nxt_warned;
    logic              need_home_ff, nxt_need_home;
    logic              mute_ff, nxt_mute;
    logic [7:0]        code_ff, nxt_code;
    logic              blink_ff, nxt_blink;

    logic any_estop, tmp_stop, hard_err;

    // Emergency inputs each watched on their own line
    assign any_estop = |i_estop | i_lanyard_trip;
    assign tmp_stop  = i_flow_jam_tmp | i_periph_off_tmp;
    assign hard_err  = i_device_jam | i_invalid_combo | i_expected_missing | (tmo_ff >= 32'(TMO_CYC));

    // =====================================================
    // Next-state logic for the mode supervisor
    always_comb begin
        nxt_state     = state_ff;
        nxt_tmr       = tmr_ff;
        nxt_step      = step_ff;
        nxt_warned    = warned_ff;
        nxt_need_home = need_home_ff;
        nxt_tmo       = 32'h0;
        nxt_blk       = blk_ff + 32'h1;
        nxt_blink     = blink_ff;
        if (blk_ff >= 32'(BLINK_CYC - 1)) begin
            nxt_blk   = 32'h0;
            nxt_blink = ~blink_ff;
        end
        // Emergency wins over every mode and halt
        if (any_estop) begin
            nxt_state     = emsc_pkg::ST_ESTOP;
            nxt_need_home = 1'b1;
            nxt_warned    = 1'b0;
        end else begin
            unique case (state_ff)
                emsc_pkg::ST_WARN: begin
                    // Horn time before any motion
                    nxt_tmr = tmr_ff + 32'h1;
                    if (tmr_ff >= 32'(WARN_CYC - 1)) begin
                        nxt_warned = 1'b1;
                        nxt_tmr    = 32'h0;
                        nxt_state  = emsc_pkg::ST_OFF;
                    end
                end
                emsc_pkg::ST_OFF: begin
                    // Step kept so auto resumes where it stopped
                    if (i_mode_selector == `EMSC_SEL_AUTO)
                        nxt_state = emsc_pkg::ST_AUTO_IDLE;
                    else if (i_mode_selector == `EMSC_SEL_MANUAL)
                        nxt_state = emsc_pkg::ST_MANUAL;
                end
                emsc_pkg::ST_MANUAL: begin
                    if (i_mode_selector != `EMSC_SEL_MANUAL)
                        nxt_state = emsc_pkg::ST_OFF;
                end
                emsc_pkg::ST_AUTO_IDLE: begin
                    if (i_mode_selector != `EMSC_SEL_AUTO)
                        nxt_state = emsc_pkg::ST_OFF;
                    else if (i_auto_start && !tmp_stop)
                        nxt_state = emsc_pkg::ST_AUTO_RUN;
                end
                emsc_pkg::ST_AUTO_RUN: begin
                    // Timeout frozen during a temporary stop so a long jam never becomes a fault
                    nxt_tmo = i_step_done ? 32'h0 : (tmp_stop ? tmo_ff : tmo_ff + 32'h1);
                    if (i_mode_selector != `EMSC_SEL_AUTO)
                        nxt_state = emsc_pkg::ST_OFF;
                    else if (hard_err)
                        nxt_state = emsc_pkg::ST_FAULT;
                    else if (i_ctrl_halt)
                        nxt_state = emsc_pkg::ST_CTRL_HALT;
                    else if (i_step_done && !tmp_stop)
                        nxt_step = step_ff + STEP_W'(1);
                    if (need_home_ff && i_at_home)
                        nxt_need_home = 1'b0;
                end
                emsc_pkg::ST_CTRL_HALT: begin
                    // Step and stored data untouched here
                    if (i_mode_selector != `EMSC_SEL_AUTO)
                        nxt_state = emsc_pkg::ST_OFF;
                    else if (i_ctrl_halt_reset)
                        nxt_state = emsc_pkg::ST_AUTO_RUN;
                end
                emsc_pkg::ST_ESTOP: begin
                    // Operator resume needed; homing follows
                    if (i_resume)
                        nxt_state = emsc_pkg::ST_WARN;
                end
                emsc_pkg::ST_FAULT: begin
                    // Selector honoured on recovery so the auto lamp never lights outside auto
                    if (i_error_reset && !hard_err)
                        nxt_state = (i_mode_selector == `EMSC_SEL_AUTO) ? emsc_pkg::ST_AUTO_IDLE
                                                                        : emsc_pkg::ST_OFF;
                end
            endcase
        end
    end

    // Registered supervisor state
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_ff     <= emsc_pkg::ST_WARN;
            tmr_ff       <= 32'h0;
            blk_ff       <= 32'h0;
            tmo_ff       <= 32'h0;
            step_ff      <= '0;
            warned_ff    <= 1'b0;
            need_home_ff <= 1'b0;
            blink_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            tmr_ff       <= nxt_tmr;
            blk_ff       <= nxt_blk;
            tmo_ff       <= nxt_tmo;
            step_ff      <= nxt_step;
            warned_ff    <= nxt_warned;
            need_home_ff <= nxt_need_home;
            blink_ff     <= nxt_blink;
        end
    end

    // =====================================================
    // Error latch and alarm mute
    always_comb begin
        nxt_code = code_ff;
        nxt_mute = mute_ff;
        if (i_estop != '0)
            nxt_code = `EMSC_ERR_ESTOP;
        else if (i_lanyard_trip)
            nxt_code = `EMSC_ERR_LANYARD;
        else if (i_device_jam)
            nxt_code = `EMSC_ERR_JAM;
        else if (tmo_ff >= 32'(TMO_CYC))
            nxt_code = `EMSC_ERR_TIMEOUT;
        else if (i_invalid_combo)
            nxt_code = `EMSC_ERR_INVALID;
        else if (i_expected_missing)
            nxt_code = `EMSC_ERR_MISSING;
        else if (!hard_err && state_ff != emsc_pkg::ST_FAULT)
            nxt_code = `EMSC_ERR_NONE;
        // New error re-arms the audible alarm; mute does not clear the code
        if (nxt_code != code_ff)
            nxt_mute = 1'b0;
        else if (i_alarm_mute_button)
            nxt_mute = 1'b1;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            code_ff <= 8'h00;
            mute_ff <= 1'b0;
        end else begin
            code_ff <= nxt_code;
            mute_ff <= nxt_mute;
        end
    end

    // =====================================================
    // Registered outputs; motion gated by mode, halt and emergency
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_motion_en      <= '0;
            o_seq_run        <= 1'b0;
            o_seq_step       <= '0;
            o_homing         <= 1'b0;
            o_out_power      <= 1'b0;
            o_auto_lamp      <= 1'b0;
            o_ctrl_halt_lamp <= 1'b0;
            o_estop_lamp     <= '0;
            o_lanyard_annunc <= 1'b0;
            o_startup_horn   <= 1'b0;
            o_error_lamp     <= 1'b0;
            o_audible_alarm  <= 1'b0;
            o_error_code     <= 8'h00;
        end else begin
            // Manual switches pass only where interlocked safe
            o_motion_en <= (!any_estop && nxt_state == emsc_pkg::ST_MANUAL && warned_ff)
                           ? (i_manual_action_switches & i_interlock_ok) : '0;
            o_seq_run   <= !any_estop && warned_ff && nxt_state == emsc_pkg::ST_AUTO_RUN
                           && !need_home_ff && !tmp_stop;
            o_homing    <= !any_estop && warned_ff && nxt_state == emsc_pkg::ST_AUTO_RUN && need_home_ff;
            o_seq_step  <= step_ff;
            o_out_power <= !any_estop && state_ff != emsc_pkg::ST_ESTOP;
            o_auto_lamp <= (state_ff == emsc_pkg::ST_AUTO_IDLE) || (state_ff == emsc_pkg::ST_AUTO_RUN)
                           || (state_ff == emsc_pkg::ST_CTRL_HALT);
            o_ctrl_halt_lamp <= (state_ff == emsc_pkg::ST_CTRL_HALT) && blink_ff;
            o_estop_lamp     <= i_estop;
            o_lanyard_annunc <= i_lanyard_trip;
            o_startup_horn   <= (state_ff == emsc_pkg::ST_WARN) && !any_estop;
            o_error_lamp     <= code_ff != `EMSC_ERR_NONE;
            o_audible_alarm  <= (code_ff != `EMSC_ERR_NONE) && !mute_ff;
            o_error_code     <= code_ff;
        end
    end
endmodule : emsc_mode_stop
`default_nettype wire

// ==== emsc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emsc_cfg.svh"
// ==========
// Port checker
module emsc_checker #(
    parameter int N_ESTOP = 4,
    parameter int N_ACT   = 4,
    parameter int STEP_W  = 8
) (
    input wire logic               i_core_clk,
    input wire logic               i_rst,
    input wire logic [1:0]         i_mode_selector,
    input wire logic [N_ESTOP-1:0] i_estop,
    input wire logic               i_lanyard_trip,
    input wire logic               i_alarm_mute_button,
    input wire logic [N_ACT-1:0]   i_manual_action_switches,
    input wire logic [N_ACT-1:0]   i_interlock_ok,
    input wire logic [N_ACT-1:0]   o_motion_en,
    input wire logic               o_seq_run,
    input wire logic [STEP_W-1:0]  o_seq_step,
    input wire logic               o_out_power,
    input wire logic               o_auto_lamp,
    input wire logic               o_ctrl_halt_lamp,
    input wire logic [N_ESTOP-1:0] o_estop_lamp,
    input wire logic               o_lanyard_annunc,
    input wire logic               o_startup_horn,
    input wire logic               o_audible_alarm
);
    default clocking cb @(posedge i_core_clk); endclocking
    // Reset clears everything, so nothing is judged inside it
    default disable iff (i_rst);
    a_estop_motion: assert property (|i_estop |=> !o_seq_run && o_motion_en == '0)
        else $error("motion kept during emergency halt");
    a_estop_power: assert property (|i_estop |-> ##2 !o_out_power)
        else $error("output power kept during emergency halt");
    a_estop_lamp_each: assert property (|i_estop |=> (o_estop_lamp & $past(i_estop)) == $past(i_estop))
        else $error("emergency lamp missing");
    a_lanyard_annunc: assert property (i_lanyard_trip |=> o_lanyard_annunc)
        else $error("lanyard annunciator not driven");
    a_horn_no_motion: assert property (o_startup_horn |-> !o_seq_run && o_motion_en == '0)
        else $error("motion during start-up warning");
    a_auto_lamp_mode: assert property (o_auto_lamp |-> $past(i_mode_selector, 2) == `EMSC_SEL_AUTO)
        else $error("auto lamp lit outside auto");
    a_halt_step_frozen: assert property (o_ctrl_halt_lamp |=> $stable(o_seq_step))
        else $error("step moved in controlled halt");
    a_off_stops_all: assert property (i_mode_selector == `EMSC_SEL_OFF [*2] |=> !o_seq_run && o_motion_en == '0)
        else $error("motion with selector off");
    a_manual_motion_gate: assert property (o_motion_en != '0 |->
        o_motion_en == $past(i_manual_action_switches & i_interlock_ok))
        else $error("manual motion not gated by interlock");
    a_mute_silences: assert property (o_audible_alarm && i_alarm_mute_button |-> ##[1:2] !o_audible_alarm)
        else $error("alarm not muted");
endmodule : emsc_checker
bind emsc_mode_stop emsc_checker #(.N_ESTOP(N_ESTOP), .N_ACT(N_ACT), .STEP_W(STEP_W)) i_emsc_checker (
    .i_core_clk              (i_core_clk),
    .i_rst                   (i_rst),
    .i_mode_selector         (i_mode_selector),
    .i_estop                 (i_estop),
    .i_lanyard_trip          (i_lanyard_trip),
    .i_alarm_mute_button     (i_alarm_mute_button),
    .i_manual_action_switches(i_manual_action_switches),
    .i_interlock_ok          (i_interlock_ok),
    .o_motion_en             (o_motion_en),
    .o_seq_run               (o_seq_run),
    .o_seq_step              (o_seq_step),
    .o_out_power             (o_out_power),
    .o_auto_lamp             (o_auto_lamp),
    .o_ctrl_halt_lamp        (o_ctrl_halt_lamp),
    .o_estop_lamp            (o_estop_lamp),
    .o_lanyard_annunc        (o_lanyard_annunc),
    .o_startup_horn          (o_startup_horn),
    .o_audible_alarm         (o_audible_alarm)
);
`default_nettype wire

// ==== emsc_machine.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Machine model: steps while running, homes on request
module emsc_machine #(
    parameter int GAP  = 8,
    parameter int HDLY = 6
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_seq_run,
    input wire logic i_homing,
    output logic     o_step_done,
    output logic     o_at_home
);
    int cnt_ff;
    // Homing takes real time, so the supervisor must wait for it
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !(i_seq_run || i_homing)) cnt_ff <= 0;
        else cnt_ff <= (cnt_ff == GAP - 1) ? 0 : cnt_ff + 1;
        o_step_done <= !i_rst && i_seq_run && cnt_ff == GAP - 1;
        if (i_rst) o_at_home <= 1'b1;
        else if (i_seq_run) o_at_home <= 1'b0;
        else if (i_homing && cnt_ff == HDLY) o_at_home <= 1'b1;
    end
endmodule : emsc_machine
`default_nettype wire

// ==== emsc_mode_stop_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emsc_cfg.svh"
module emsc_mode_stop_tb_top;
    localparam int WARN = 20;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] sel = `EMSC_SEL_OFF;
    logic       start = 0, halt = 0, hrst = 0, resume = 0, erst = 0, mute = 0, lany = 0;
    logic       jam = 0, per = 0, djam = 0, inv = 0, miss = 0;
    logic [3:0] estop = 0, sw = 0, ilk = 0, men, slamp;
    logic       home, done, run, homing, pwr, alamp, hlamp, ann, horn, elamp, alarm;
    logic [7:0] step, code, keep;
    int         num_errors = 0, checks_done = 0;
    // ==========
    // Clock, block and machine
    initial forever #12.5 clk = ~clk;
    emsc_mode_stop #(.WARN_CYC(WARN), .BLINK_CYC(4), .TMO_CYC(50)) i_emsc_mode_stop (
        .i_core_clk(clk), .i_rst(rst), .i_mode_selector(sel), .i_auto_start(start), .i_ctrl_halt(halt),
        .i_ctrl_halt_reset(hrst), .i_resume(resume), .i_error_reset(erst), .i_alarm_mute_button(mute),
        .i_estop(estop), .i_lanyard_trip(lany), .i_manual_action_switches(sw), .i_interlock_ok(ilk),
        .i_at_home(home), .i_step_done(done), .i_flow_jam_tmp(jam), .i_periph_off_tmp(per),
        .i_device_jam(djam), .i_invalid_combo(inv), .i_expected_missing(miss), .o_motion_en(men),
        .o_seq_run(run), .o_seq_step(step), .o_homing(homing), .o_out_power(pwr), .o_auto_lamp(alamp),
        .o_ctrl_halt_lamp(hlamp), .o_estop_lamp(slamp), .o_lanyard_annunc(ann), .o_startup_horn(horn),
        .o_error_lamp(elamp), .o_audible_alarm(alarm), .o_error_code(code));
    emsc_machine i_emsc_machine (.i_core_clk(clk), .i_rst(rst), .i_seq_run(run), .i_homing(homing),
        .o_step_done(done), .o_at_home(home));
    // ==========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // Button presses last one cycle, like a quick operator tap
    task automatic t_start;
        @(posedge clk) start <= 1;
        @(posedge clk) start <= 0;
    endtask : t_start
    // ==========
    // Scenarios
    task automatic t_startup;
        cyc(3);
        chk("horn", 1, horn);
        chk("early motion", 0, {run, men});
        cyc(WARN);
        chk("horn end", 0, horn);
        @(posedge clk) sel <= `EMSC_SEL_AUTO;
        cyc(5);
        chk("auto lamp", 1, alamp);
        chk("run unstarted", 0, run);
        t_start();
        cyc(20);
        chk("run", 1, run);
        chk("stepped", 1, step != 0);
    endtask : t_startup
    task automatic t_halt;
        logic [1:0] seen;
        seen = 0;
        @(posedge clk) halt <= 1;
        @(posedge clk) halt <= 0;
        cyc(3);
        keep = step;
        repeat (12) @(posedge clk) seen |= {hlamp, ~hlamp};
        chk("blink", 3, seen);
        chk("halt step", keep, step);
        chk("halt motion", 0, {run, men});
        @(posedge clk) hrst <= 1;
        @(posedge clk) hrst <= 0;
        cyc(4);
        chk("halt left", 1, run);
        @(posedge clk) sel <= `EMSC_SEL_OFF;
        cyc(4);
        keep = step;
        chk("off run", 0, run);
        @(posedge clk) sel <= `EMSC_SEL_AUTO;
        cyc(4);
        chk("off step", keep, step);
        t_start();
        cyc(3);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {jam, per} <= 2'h1 << k;
            cyc(4);
            chk("paused", 0, run);
            @(posedge clk) {jam, per} <= 2'h0;
            cyc(4);
            chk("self restart", 1, run);
        end
        // A pause longer than the step timeout must still restart on its own
        @(posedge clk) per <= 1'b1;
        cyc(60);
        chk("long pause code", 0, code);
        @(posedge clk) per <= 1'b0;
        cyc(4);
        chk("long pause restart", 1, run);
    endtask : t_halt
    task automatic t_err;
        logic [7:0] codes [3];
        codes = '{`EMSC_ERR_JAM, `EMSC_ERR_INVALID, `EMSC_ERR_MISSING};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) {djam, inv, miss} <= 3'h4 >> k;
            cyc(4);
            chk("code", codes[k], code);
            chk("err lamp alarm", 3, {elamp, alarm});
            @(posedge clk) mute <= 1;
            @(posedge clk) mute <= 0;
            cyc(3);
            chk("muted", 0, alarm);
            chk("code kept", codes[k], code);
            @(posedge clk) {djam, inv, miss} <= 3'h0;
            cyc(4);
            chk("err stopped", 0, run);
            @(posedge clk) erst <= 1;
            @(posedge clk) erst <= 0;
            cyc(4);
            chk("cleared", 0, code);
            t_start();
            cyc(4);
        end
    endtask : t_err
    task automatic t_estop;
        @(posedge clk) estop <= 4'h4;
        cyc(3);
        chk("estop motion", 0, {run, men});
        chk("estop power", 0, pwr);
        chk("estop lamp", 4'h4, slamp);
        chk("estop code", `EMSC_ERR_ESTOP, code);
        @(posedge clk) lany <= 1;
        cyc(3);
        chk("annunc", 1, ann);
        @(posedge clk) estop <= 4'h0;
        cyc(3);
        chk("lanyard code", `EMSC_ERR_LANYARD, code);
        @(posedge clk) lany <= 1'b0;
        cyc(4);
        chk("estop held", 0, run);
        @(posedge clk) resume <= 1;
        @(posedge clk) resume <= 0;
        cyc(3);
        chk("power back", 1, pwr);
        cyc(WARN + 4);
        t_start();
        cyc(2);
        chk("homing", 2, {homing, run});
        cyc(14);
        chk("home run", 1, run);
    endtask : t_estop
    task automatic t_manual;
        @(posedge clk) sel <= `EMSC_SEL_MANUAL;
        cyc(4);
        chk("manual stop", 0, {run, men, alamp});
        @(posedge clk) halt <= 1;
        cyc(3);
        chk("no halt manual", 0, hlamp);
        @(posedge clk) {halt, sw, ilk} <= 9'h0b6;
        cyc(3);
        chk("interlock", 4'h2, men);
        @(posedge clk) sw <= 4'h0;
        cyc(3);
        chk("spring return", 0, men);
    endtask : t_manual
    // ==========
    // Main sequence and watchdog
    initial begin
        cyc(5);
        rst <= 1'b0;
        t_startup();
        t_halt();
        t_err();
        t_estop();
        t_manual();
        end_sim();
    end
    initial begin
        #(25 * 8000);
        num_errors++;
        end_sim();
    end
endmodule : emsc_mode_stop_tb_top
`default_nettype wire
